// [design/mais_map.svh]
`ifndef MAIS_MAP_SVH
`define MAIS_MAP_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define MAIS_AXIS_STRIDE_LOG2   4
`define MAIS_OFS_ABN_CAUSE      4'h0
`define MAIS_OFS_MOT_CAUSE      4'h4
`define MAIS_OFS_FACTOR_MASK    4'h8
`define MAIS_OFS_STOP_ENABLE    4'hc
`define MAIS_OFS_CARD_CTRL      12'h040
`define MAIS_OFS_CARD_IRQ       12'h044
`define MAIS_AXIS_AREA_TOP      6'h00

// ---------------------------------------------------------------
// abnormal-stop cause bits
// ---------------------------------------------------------------
`define MAIS_ABN_SOFT_POS       0
`define MAIS_ABN_SOFT_NEG       1
`define MAIS_ABN_GEN_CMP        3
`define MAIS_ABN_END_POS        5
`define MAIS_ABN_END_NEG        6
`define MAIS_ABN_SERVO_ALARM    7
`define MAIS_ABN_SYNC_STOP      8
`define MAIS_ABN_EMERGENCY      9
`define MAIS_ABN_SLOW_STOP      10
`define MAIS_ABN_INTERP_ERR     11
`define MAIS_ABN_INTERP_ERR_B   12
`define MAIS_ABN_INTERP_OTHER   13
`define MAIS_ABN_PULSER_OVF     14
`define MAIS_ABN_INTERP_OVF     15
`define MAIS_ABN_ENCODER_ERR    16
`define MAIS_ABN_PULSER_ERR     17
`define MAIS_ABN_VALID          32'h0003f7eb

// ---------------------------------------------------------------
// motion-event cause bits
// ---------------------------------------------------------------
`define MAIS_MOT_NORMAL_STOP    0
`define MAIS_MOT_NEXT_START     1
`define MAIS_MOT_PREREG_EMPTY   2
`define MAIS_MOT_ACCEL_START    4
`define MAIS_MOT_ACCEL_END      5
`define MAIS_MOT_DECEL_START    6
`define MAIS_MOT_DECEL_END      7
`define MAIS_MOT_GEN_CMP        11
`define MAIS_MOT_TRIG_CMP       12
`define MAIS_MOT_CNT_LATCH      14
`define MAIS_MOT_ORIGIN_LATCH   15
`define MAIS_MOT_SLOW_DOWN      16
`define MAIS_MOT_SYNC_START     19
`define MAIS_MOT_AXIS_STOP      31
`define MAIS_MOT_VALID          32'h8009d8f7
`define MAIS_MOT_MASKABLE       32'h0009d8f7

// ---------------------------------------------------------------
// reset value and enable bit positions
// ---------------------------------------------------------------
`define MAIS_RST_WORD           32'h00000000
`define MAIS_CARD_EN_BIT        0
`define MAIS_STOP_EN_BIT        0

`endif

// [design/mais_pkg.sv]
package mais_pkg;

   typedef logic [31:0] mais_word_t;

   typedef enum logic [0:0] {
      MAIS_APB_IDLE,
      MAIS_APB_RESP
   } mais_apb_state_t;

endpackage

// [design/mais_reset_sync.sv]
`timescale 1ns/1ps

module mais_reset_sync
(
   input  wire logic core_clk,
   input  wire logic reset_n,
   output logic      sync_reset_n
);

   logic             meta_reg;

   // ---------------------------------------------------------------
   // asynchronous assert, synchronous release
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta_reg     <= 1'b0;
         sync_reset_n <= 1'b0;
      end
      else
      begin
         meta_reg     <= 1'b1;
         sync_reset_n <= meta_reg;
      end
   end

endmodule

// [design/mais_axis_cause.sv]
`timescale 1ns/1ps
`include "mais_map.svh"

module mais_axis_cause
(
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   input  wire mais_pkg::mais_word_t abn_set,
   input  wire mais_pkg::mais_word_t mot_set,
   input  wire logic              capture,
   input  wire logic              clear,
   output mais_pkg::mais_word_t   abn_reg,
   output mais_pkg::mais_word_t   mot_reg,
   output mais_pkg::mais_word_t   mot_snap_reg
);

   mais_pkg::mais_word_t          abn_snap_reg;
   mais_pkg::mais_word_t          abn_next;
   mais_pkg::mais_word_t          mot_next;

   // only bits handed to software are cleared; a set in the same cycle wins
   assign abn_next = ((abn_reg & ~(clear ? abn_snap_reg : `MAIS_RST_WORD)) | abn_set)
                     & `MAIS_ABN_VALID;
   assign mot_next = ((mot_reg & ~(clear ? mot_snap_reg : `MAIS_RST_WORD)) | mot_set)
                     & `MAIS_MOT_VALID;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         abn_reg      <= `MAIS_RST_WORD;
         mot_reg      <= `MAIS_RST_WORD;
         abn_snap_reg <= `MAIS_RST_WORD;
         mot_snap_reg <= `MAIS_RST_WORD;
      end
      else
      begin
         abn_reg <= abn_next;
         mot_reg <= mot_next;
         if (capture)
         begin
            abn_snap_reg <= abn_reg;
            mot_snap_reg <= mot_reg;
         end
      end
   end

endmodule

// [design/mais_top.sv]
// Function
// - abnormal-cause read snaps both words, then clears both
// - two 32-bit cause words per axis
// - factor mask never hides abnormal-stop bits
// - masked motion events raise no interrupt
// - soft limit stops set bits 0, 1
// - comparator stop sets abnormal bit 3
// - end limits and servo alarm: bits 5-7
// - shared sync stop sets abnormal bit 8
// - shared emergency stop sets abnormal bit 9
// - slow-down stop sets abnormal bit 10
// - interpolation stops set bits 12, 13
// - pulser and counter overflow: bits 14, 15
// - encoder and pulser errors: bits 16, 17
// - stop, next start, pre-register empty: 0-2
// - comparator matches set bits 11, 12
// - counter latch bit 14, axes 2, 3
// - origin latch bit 15, slow-down bit 16
// - shared sync start sets motion bit 19
// - enabled axis stop sets bit 31, interrupts
// - axis-stop enable separate from factor mask
// - card interrupt request state is readable
// - motion bits below 31 interrupt only when mask one
// - interrupt request needs card-level enable
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "mais_map.svh"

module mais_top
#(
   parameter int              NUM_AXES   = 4,
   parameter logic [3:0]      LATCH_AXES = 4'hc
)
(
   input  wire logic                 core_clk,
   input  wire logic                 reset_n,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic                      pready,
   output logic [31:0]               prdata,
   output logic                      pslverr,
   input  wire logic [NUM_AXES-1:0]  soft_limit_pos_stop,
   input  wire logic [NUM_AXES-1:0]  soft_limit_neg_stop,
   input  wire logic [NUM_AXES-1:0]  gen_cmp_stop,
   input  wire logic [NUM_AXES-1:0]  end_limit_pos_stop,
   input  wire logic [NUM_AXES-1:0]  end_limit_neg_stop,
   input  wire logic [NUM_AXES-1:0]  servo_alarm_stop,
   input  wire logic                 shared_sync_stop_input,
   input  wire logic                 shared_emergency_stop_input,
   input  wire logic [NUM_AXES-1:0]  slow_down_stop,
   input  wire logic [NUM_AXES-1:0]  interp_error_stop,
   input  wire logic [NUM_AXES-1:0]  interp_other_axis_stop,
   input  wire logic [NUM_AXES-1:0]  pulser_overflow_stop,
   input  wire logic [NUM_AXES-1:0]  interp_counter_overflow,
   input  wire logic [NUM_AXES-1:0]  encoder_signal_error,
   input  wire logic [NUM_AXES-1:0]  pulser_signal_error,
   input  wire logic [NUM_AXES-1:0]  normal_stop,
   input  wire logic [NUM_AXES-1:0]  next_cmd_start,
   input  wire logic [NUM_AXES-1:0]  prereg2_empty,
   input  wire logic [NUM_AXES-1:0]  accel_start,
   input  wire logic [NUM_AXES-1:0]  accel_end,
   input  wire logic [NUM_AXES-1:0]  decel_start,
   input  wire logic [NUM_AXES-1:0]  decel_end,
   input  wire logic [NUM_AXES-1:0]  gen_cmp_match,
   input  wire logic [NUM_AXES-1:0]  trig_cmp_match,
   input  wire logic [NUM_AXES-1:0]  counter_latch,
   input  wire logic [NUM_AXES-1:0]  origin_input_latched,
   input  wire logic [NUM_AXES-1:0]  slow_down_input,
   input  wire logic                 shared_sync_start_input,
   output logic                      host_irq
);

   // ---------------------------------------------------------------
   // reset
   // ---------------------------------------------------------------
   logic                             rst_n;

   mais_reset_sync u_rst
   (
      .core_clk     (core_clk),
      .reset_n      (reset_n),
      .sync_reset_n (rst_n)
   );

   // ---------------------------------------------------------------
   // level inputs turned into one-cycle events
   // ---------------------------------------------------------------
   logic                             sync_stop_prev_reg;
   logic                             emerg_prev_reg;
   logic                             sync_start_prev_reg;
   logic [NUM_AXES-1:0]              slow_prev_reg;
   wire                              sync_stop_rise;
   wire                              emerg_rise;
   wire                              sync_start_rise;
   wire  [NUM_AXES-1:0]              slow_rise;

   assign sync_stop_rise  = shared_sync_stop_input & ~sync_stop_prev_reg;
   assign emerg_rise      = shared_emergency_stop_input & ~emerg_prev_reg;
   assign sync_start_rise = shared_sync_start_input & ~sync_start_prev_reg;
   assign slow_rise       = slow_down_input & ~slow_prev_reg;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_stop_prev_reg  <= 1'b0;
         emerg_prev_reg      <= 1'b0;
         sync_start_prev_reg <= 1'b0;
         slow_prev_reg       <= '0;
      end
      else
      begin
         sync_stop_prev_reg  <= shared_sync_stop_input;
         emerg_prev_reg      <= shared_emergency_stop_input;
         sync_start_prev_reg <= shared_sync_start_input;
         slow_prev_reg       <= slow_down_input;
      end
   end

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   mais_pkg::mais_apb_state_t        apb_state_reg;
   wire                              access;
   wire                              first_cycle;
   wire                              done;
   wire  [1:0]                       ax_idx;
   wire  [3:0]                       ax_ofs;
   wire                              in_axis;
   wire                              hit_abn;
   wire                              hit_mot;
   wire                              hit_mask;
   wire                              hit_stop;
   wire                              hit_card;
   wire                              hit_irq;
   wire                              mapped;

   assign access      = psel & penable;
   assign first_cycle = access & (apb_state_reg == mais_pkg::MAIS_APB_IDLE);
   assign done        = access & (apb_state_reg == mais_pkg::MAIS_APB_RESP);
   assign ax_idx      = paddr[`MAIS_AXIS_STRIDE_LOG2+1:`MAIS_AXIS_STRIDE_LOG2];
   assign ax_ofs      = paddr[3:0];
   assign in_axis     = (paddr[11:6] == `MAIS_AXIS_AREA_TOP) && (int'(ax_idx) < NUM_AXES);
   assign hit_abn     = in_axis && (ax_ofs == `MAIS_OFS_ABN_CAUSE);
   assign hit_mot     = in_axis && (ax_ofs == `MAIS_OFS_MOT_CAUSE);
   assign hit_mask    = in_axis && (ax_ofs == `MAIS_OFS_FACTOR_MASK);
   assign hit_stop    = in_axis && (ax_ofs == `MAIS_OFS_STOP_ENABLE);
   assign hit_card    = (paddr == `MAIS_OFS_CARD_CTRL);
   assign hit_irq     = (paddr == `MAIS_OFS_CARD_IRQ);
   assign mapped      = hit_abn | hit_mot | hit_mask | hit_stop | hit_card | hit_irq;

   // ---------------------------------------------------------------
   // per-axis cause words, mask and axis-stop enable
   // ---------------------------------------------------------------
   mais_pkg::mais_word_t             abn_word [NUM_AXES];
   mais_pkg::mais_word_t             mot_word [NUM_AXES];
   mais_pkg::mais_word_t             mot_snap [NUM_AXES];
   mais_pkg::mais_word_t             mask_reg [NUM_AXES];
   logic [NUM_AXES-1:0]              stop_en_reg;
   logic [NUM_AXES-1:0]              pending;
   logic                             card_en_reg;

   genvar a;
   generate
      for (a = 0; a < NUM_AXES; a++)
      begin : g_axis
         mais_pkg::mais_word_t       abn_set;
         mais_pkg::mais_word_t       mot_set;
         wire                        this_ax;
         wire                        any_stop;

         assign this_ax = (int'(ax_idx) == a);

         always_comb
         begin
            abn_set = `MAIS_RST_WORD;
            abn_set[`MAIS_ABN_SOFT_POS]     = soft_limit_pos_stop[a];
            abn_set[`MAIS_ABN_SOFT_NEG]     = soft_limit_neg_stop[a];
            abn_set[`MAIS_ABN_GEN_CMP]      = gen_cmp_stop[a];
            abn_set[`MAIS_ABN_END_POS]      = end_limit_pos_stop[a];
            abn_set[`MAIS_ABN_END_NEG]      = end_limit_neg_stop[a];
            abn_set[`MAIS_ABN_SERVO_ALARM]  = servo_alarm_stop[a];
            abn_set[`MAIS_ABN_SYNC_STOP]    = sync_stop_rise;
            abn_set[`MAIS_ABN_EMERGENCY]    = emerg_rise;
            abn_set[`MAIS_ABN_SLOW_STOP]    = slow_down_stop[a];
            abn_set[`MAIS_ABN_INTERP_ERR_B] = interp_error_stop[a];
            abn_set[`MAIS_ABN_INTERP_OTHER] = interp_other_axis_stop[a];
            abn_set[`MAIS_ABN_PULSER_OVF]   = pulser_overflow_stop[a];
            abn_set[`MAIS_ABN_INTERP_OVF]   = interp_counter_overflow[a];
            abn_set[`MAIS_ABN_ENCODER_ERR]  = encoder_signal_error[a];
            abn_set[`MAIS_ABN_PULSER_ERR]   = pulser_signal_error[a];
         end

         // every stop, normal or abnormal, feeds the axis-stop event
         assign any_stop = normal_stop[a] | (|abn_set);

         always_comb
         begin
            mot_set = `MAIS_RST_WORD;
            mot_set[`MAIS_MOT_NORMAL_STOP]   = normal_stop[a];
            mot_set[`MAIS_MOT_NEXT_START]    = next_cmd_start[a];
            mot_set[`MAIS_MOT_PREREG_EMPTY]  = prereg2_empty[a];
            mot_set[`MAIS_MOT_ACCEL_START]   = accel_start[a];
            mot_set[`MAIS_MOT_ACCEL_END]     = accel_end[a];
            mot_set[`MAIS_MOT_DECEL_START]   = decel_start[a];
            mot_set[`MAIS_MOT_DECEL_END]     = decel_end[a];
            mot_set[`MAIS_MOT_GEN_CMP]       = gen_cmp_match[a];
            mot_set[`MAIS_MOT_TRIG_CMP]      = trig_cmp_match[a];
            mot_set[`MAIS_MOT_CNT_LATCH]     = counter_latch[a] & LATCH_AXES[a];
            mot_set[`MAIS_MOT_ORIGIN_LATCH]  = origin_input_latched[a];
            mot_set[`MAIS_MOT_SLOW_DOWN]     = slow_rise[a];
            mot_set[`MAIS_MOT_SYNC_START]    = sync_start_rise;
            mot_set[`MAIS_MOT_AXIS_STOP]     = any_stop & stop_en_reg[a];
         end

         mais_axis_cause u_cause
         (
            .core_clk     (core_clk),
            .rst_n        (rst_n),
            .abn_set      (abn_set),
            .mot_set      (mot_set),
            .capture      (first_cycle & ~pwrite & hit_abn & this_ax),
            .clear        (done & ~pwrite & hit_abn & this_ax),
            .abn_reg      (abn_word[a]),
            .mot_reg      (mot_word[a]),
            .mot_snap_reg (mot_snap[a])
         );

         // abnormal bits bypass the mask; bit 31 has its own enable
         assign pending[a] = (|abn_word[a])
                           | (|(mot_word[a] & mask_reg[a]))
                           | mot_word[a][`MAIS_MOT_AXIS_STOP];

         always_ff @(posedge core_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               mask_reg[a]    <= `MAIS_RST_WORD;
               stop_en_reg[a] <= 1'b0;
            end
            else if (done & pwrite & this_ax)
            begin
               if (hit_mask)
                  mask_reg[a] <= pwdata & `MAIS_MOT_MASKABLE;
               if (hit_stop)
                  stop_en_reg[a] <= pwdata[`MAIS_STOP_EN_BIT];
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // read data selection
   // ---------------------------------------------------------------
   mais_pkg::mais_word_t             rd_axis;
   mais_pkg::mais_word_t             rd_card;
   mais_pkg::mais_word_t             rd_val;

   always_comb
   begin
      rd_axis = `MAIS_RST_WORD;
      for (int i = 0; i < NUM_AXES; i++)
      begin
         if (int'(ax_idx) == i)
         begin
            if (hit_abn)
               rd_axis = abn_word[i];
            else if (hit_mot)
               rd_axis = mot_snap[i];
            else if (hit_mask)
               rd_axis = mask_reg[i];
            else if (hit_stop)
               rd_axis[`MAIS_STOP_EN_BIT] = stop_en_reg[i];
         end
      end
   end

   always_comb
   begin
      rd_card = `MAIS_RST_WORD;
      if (hit_card)
         rd_card[`MAIS_CARD_EN_BIT] = card_en_reg;
      else if (hit_irq)
         rd_card[`MAIS_CARD_EN_BIT] = host_irq;
   end

   assign rd_val = rd_axis | rd_card;

   // ---------------------------------------------------------------
   // apb slave: one wait state on every access
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         apb_state_reg <= mais_pkg::MAIS_APB_IDLE;
         pready        <= 1'b0;
         prdata        <= `MAIS_RST_WORD;
         pslverr       <= 1'b0;
      end
      else
      begin
         case (apb_state_reg)
            mais_pkg::MAIS_APB_IDLE:
            begin
               if (access)
               begin
                  apb_state_reg <= mais_pkg::MAIS_APB_RESP;
                  pready        <= 1'b1;
                  prdata        <= pwrite ? `MAIS_RST_WORD : rd_val;
                  pslverr       <= ~mapped;
               end
            end
            mais_pkg::MAIS_APB_RESP:
            begin
               apb_state_reg <= mais_pkg::MAIS_APB_IDLE;
               pready        <= 1'b0;
               pslverr       <= 1'b0;
            end
            default:
            begin
               apb_state_reg <= mais_pkg::MAIS_APB_IDLE;
               pready        <= 1'b0;
               pslverr       <= 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // card enable and host interrupt request
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         card_en_reg <= 1'b0;
         host_irq    <= 1'b0;
      end
      else
      begin
         if (done & pwrite & hit_card)
            card_en_reg <= pwdata[`MAIS_CARD_EN_BIT];
         // level request: stays up while the card is enabled and any cause is pending
         host_irq <= card_en_reg & (|pending);
      end
   end

endmodule

// [test/mais_top_asserts.sv]
`timescale 1ns/1ps
module mais_top_asserts
#(
   parameter int NUM_AXES = 4
)
(
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   input  wire logic        host_irq
);
   // ----
   // bus and interrupt checks
   // ----
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   wire done    = psel && penable && pready;
   wire rd      = done && !pwrite;
   wire in_axis = paddr < NUM_AXES * 16;
   property p_answer; psel && penable && !pready |=> pready; endproperty
   a_answer: assert property (p_answer) else $error("late answer");
   property p_single; pready |=> !pready; endproperty
   a_single: assert property (p_single) else $error("ready too long");
   property p_unmap;
      done && !in_axis && paddr != 12'h040 && paddr != 12'h044 |-> pslverr;
   endproperty
   a_unmap: assert property (p_unmap) else $error("no slave error");
   property p_mapped; done && in_axis |-> !pslverr; endproperty
   a_mapped: assert property (p_mapped) else $error("bad slave error");
   property p_abn_rsv;
      rd && in_axis && paddr[3:0] == 4'h0 |-> (prdata & ~32'h0003f7eb) == 32'h0;
   endproperty
   a_abn_rsv: assert property (p_abn_rsv) else $error("abn reserved set");
   property p_mot_rsv;
      rd && in_axis && paddr[3:0] == 4'h4 |-> (prdata & ~32'h8009d8f7) == 32'h0;
   endproperty
   a_mot_rsv: assert property (p_mot_rsv) else $error("mot reserved set");
   property p_sts; rd && paddr == 12'h044 |-> prdata == 32'($past(host_irq)); endproperty
   a_sts: assert property (p_sts) else $error("irq status wrong");
   property p_card_off;
      done && pwrite && paddr == 12'h040 && !pwdata[0] |-> ##2 !host_irq;
   endproperty
   a_card_off: assert property (p_card_off) else $error("irq while off");
endmodule
bind mais_top mais_top_asserts #(.NUM_AXES(NUM_AXES)) mais_top_asserts_inst (.*);

// [test/mais_host_model.sv]
`timescale 1ns/1ps
module mais_host_model
(
   input  wire logic       core_clk,
   input  wire logic       host_irq,
   output logic      [7:0] irq_edges
);
   // ----
   // host side: counts requests seen on the level line
   // ----
   logic irq_prev = 1'b0;
   initial irq_edges = 8'h00;
   always @(posedge core_clk)
   begin
      if (host_irq === 1'b1 && !irq_prev)
         irq_edges <= irq_edges + 8'h01;
      irq_prev <= (host_irq === 1'b1);
   end
endmodule

// [test/motion_axis_interrupt_status_bench.sv]
`timescale 1ns/1ps
module motion_axis_interrupt_status_bench;
   // ----
   // stimulus and checking
   // ----
   logic        core_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic        pready, pslverr, host_irq, e;
   logic [3:0]  ev [25];
   logic [2:0]  sh = 3'h0;
   logic [7:0]  irq_edges;
   int          n_mismatch = 0, n_checks = 0, cyc = 0, m;
   // cause bit per input; 32 and up lands in the motion word
   int map_tbl [28] = '{0, 1, 3, 5, 6, 7, 10, 12, 13, 14, 15, 16, 17,
      32, 33, 34, 36, 37, 38, 39, 43, 44, 46, 47, 48, 8, 9, 51};
   always #50 core_clk = ~core_clk;
   mais_top mais_top_inst (.core_clk, .reset_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .prdata, .pslverr, .host_irq,
      .soft_limit_pos_stop(ev[0]), .soft_limit_neg_stop(ev[1]), .gen_cmp_stop(ev[2]),
      .end_limit_pos_stop(ev[3]), .end_limit_neg_stop(ev[4]), .servo_alarm_stop(ev[5]),
      .slow_down_stop(ev[6]), .interp_error_stop(ev[7]), .interp_other_axis_stop(ev[8]),
      .pulser_overflow_stop(ev[9]), .interp_counter_overflow(ev[10]),
      .encoder_signal_error(ev[11]), .pulser_signal_error(ev[12]), .normal_stop(ev[13]),
      .next_cmd_start(ev[14]), .prereg2_empty(ev[15]), .accel_start(ev[16]),
      .accel_end(ev[17]), .decel_start(ev[18]), .decel_end(ev[19]),
      .gen_cmp_match(ev[20]), .trig_cmp_match(ev[21]), .counter_latch(ev[22]),
      .origin_input_latched(ev[23]), .slow_down_input(ev[24]),
      .shared_sync_stop_input(sh[0]), .shared_emergency_stop_input(sh[1]),
      .shared_sync_start_input(sh[2]));
   mais_host_model mais_host_model_inst (.core_clk, .host_irq, .irq_edges);
   task automatic chk(string nm, logic [31:0] s, logic [31:0] x);
      n_checks++;
      if (s !== x)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
      end
   endtask
   // samples before the edge's updates land, so pready seen is the settled one
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      int n;
      @(posedge core_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
         n_mismatch++;
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic rd(logic [11:0] a, logic [31:0] x, string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, r, x);
   endtask
   task automatic pz(int i, logic [3:0] v);
      if (i < 25) ev[i] <= v;
      else sh[i-25] <= 1'b1;
      @(posedge core_clk);
      if (i < 25) ev[i] <= 4'h0;
      else sh[i-25] <= 1'b0;
      @(posedge core_clk);
   endtask
   // cause to request is two edges; three leaves margin
   task automatic irq(logic x);
      repeat (3) @(posedge core_clk);
      chk("host_irq", 32'(host_irq), 32'(x));
   endtask
   task automatic t_regs;
      for (int i = 0; i < 16; i++) rd(12'(i * 4), 32'h0, "reset value");
      rd(12'h044, 32'h0, "irq status");
      apb(1'b1, 12'h028, 32'hffffffff);
      rd(12'h028, 32'h0009d8f7, "factor mask");
      apb(1'b1, 12'h02c, 32'hffffffff);
      rd(12'h02c, 32'h1, "stop enable");
      apb(1'b1, 12'h02c, 32'h0);
      apb(1'b1, 12'h028, 32'h0);
      apb(1'b1, 12'h020, 32'hffffffff);
      rd(12'h020, 32'h0, "cause write ignored");
      apb(1'b0, 12'h048, 32'h0);
      chk("unmapped", 32'(e), 32'h1);
      $display("test regs done");
   endtask
   task automatic t_irq;
      apb(1'b1, 12'h040, 32'h1);
      pz(13, 4'h1);
      irq(1'b0);
      rd(12'h044, 32'h0, "status off");
      apb(1'b1, 12'h008, 32'h1);
      irq(1'b1);
      rd(12'h044, 32'h1, "status on");
      apb(1'b1, 12'h040, 32'h0);
      irq(1'b0);
      apb(1'b1, 12'h040, 32'h1);
      irq(1'b1);
      rd(12'h000, 32'h0, "abn empty");
      rd(12'h004, 32'h1, "mot stop");
      irq(1'b0);
      apb(1'b1, 12'h008, 32'h0);
      pz(5, 4'h1);
      irq(1'b1);
      rd(12'h000, 32'h80, "alarm");
      apb(1'b1, 12'h00c, 32'h1);
      pz(13, 4'h1);
      irq(1'b1);
      rd(12'h000, 32'h0, "abn none");
      rd(12'h004, 32'h80000001, "axis stop");
      pz(3, 4'h1);
      rd(12'h000, 32'h20, "limit stop");
      rd(12'h004, 32'h80000000, "error stop");
      apb(1'b1, 12'h00c, 32'h0);
      pz(13, 4'h1);
      rd(12'h000, 32'h0, "abn none");
      rd(12'h004, 32'h1, "stop disabled");
      chk("irq edges", 32'(irq_edges), 32'h5);
      $display("test irq done");
   endtask
   task automatic t_events;
      for (int i = 0; i < 28; i++)
      begin
         m = map_tbl[i];
         pz(i, 4'h4);
         rd(12'h020, m < 32 ? 32'h1 << m : 32'h0, "abn bit");
         rd(12'h024, m > 31 ? 32'h1 << (m - 32) : 32'h0, "mot bit");
         rd(12'h020, 32'h0, "abn cleared");
         rd(12'h024, 32'h0, "mot cleared");
      end
      // shared stop, emergency and start edges above landed on axis 1 too
      pz(22, 4'h2);
      rd(12'h010, 32'h00000300, "abn axis1");
      rd(12'h014, 32'h00080000, "no latch axis1");
      $display("test events done");
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_mismatch++;
         summarize;
      end
   end
   initial
   begin
      foreach (ev[i]) ev[i] = 4'h0;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      t_regs;
      t_irq;
      t_events;
      summarize;
   end
endmodule
